/* File: alert_regs_pkg.sv */
package alert_regs_pkg;
   // register offsets
   localparam logic [7:0] FIRST_ALERT_OFS = 8'h03;
   localparam logic [7:0] LOW_FLAGS_OFS = 8'h0C;
   localparam logic [7:0] HIGH_FLAGS_OFS = 8'h0E;
   localparam logic [7:0] EVENT_COUNT_OFS = 8'h36;
   localparam logic [7:0] THRESH_BASE_OFS = 8'h38; // 38h..3Fh, lsb then msb
   localparam logic [7:0] HYST_BASE_OFS = 8'h40; // 40h chan0, 41h chan1
   // field positions and widths
   localparam int EVENT_FIELD_LSB = 4;
   localparam int CHID_FIELD_LSB = 4;
   localparam int HYST_WIDTH = 6;
   localparam int COUNT_WIDTH = 4;
   localparam int DATA_WIDTH = 12;
   localparam int FLAG_WIDTH = 2;
   // reset values
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [3:0] MSB_RESET = 4'h0;
   localparam logic [5:0] HYST_RESET = 6'h00;
   localparam logic [3:0] COUNT_RESET = 4'h0;
   // first-alert channel codes
   localparam logic [3:0] CHID_CHAN0 = 4'h0;
   localparam logic [3:0] CHID_CHAN1 = 4'h1;
endpackage : alert_regs_pkg

/* File: alert_flag_bank.sv */
// latched alert flags with write-one-to-clear
module alert_flag_bank #(
   parameter int WIDTH = alert_regs_pkg::FLAG_WIDTH
) (
   input wire logic clk_sys, // system clock
   input wire logic reset_n, // async reset, active low
   input wire logic [WIDTH-1:0] set_pulse, // comparator alert events
   input wire logic clr_wr, // host write to this flag register
   input wire logic [WIDTH-1:0] clr_data, // write data, ones clear
   input wire logic soft_clear, // general-call reset clears all flags except those set in the same cycle
   output logic [WIDTH-1:0] flags // latched flags
);
   // set beats both clear paths so no alert is lost
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         flags <= '0;
      end
      else if (soft_clear)
      begin
         flags <= set_pulse;
      end
      else if (clr_wr)
      begin
         flags <= (flags & ~clr_data) | set_pulse;
      end
      else
      begin
         flags <= flags | set_pulse;
      end
   end

   property p_set_wins;
      @(posedge clk_sys) disable iff (!reset_n) (|set_pulse) |=> ((flags & $past(set_pulse)) == $past(set_pulse));
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("flag set event lost");

   property p_zero_keeps;
      @(posedge clk_sys) disable iff (!reset_n)
         (clr_wr && !soft_clear) |=>
         ((flags & ~$past(clr_data)) == (($past(flags) | $past(set_pulse)) & ~$past(clr_data)));
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed a flag");

   property p_soft_clear;
      @(posedge clk_sys) disable iff (!reset_n) (soft_clear && set_pulse == '0) |=> (flags == '0) [*2];
   endproperty
   a_soft_clear: assert property (p_soft_clear) else $error("soft reset left a flag");

   c_clear_one: cover property (@(posedge clk_sys) disable iff (!reset_n) clr_wr && (|(flags & clr_data)));
endmodule // alert_flag_bank

/* File: window_channel_compare.sv */
// one channel: low and high comparators with hysteresis and event counting
module window_channel_compare (
   input wire logic clk_sys, // system clock
   input wire logic reset_n, // async reset, active low
   input wire logic restart, // sequence start or soft reset
   input wire logic sample_valid, // conversion result for this channel
   input wire logic [11:0] sample_data, // conversion result
   input wire logic [11:0] high_thresh, // high threshold
   input wire logic [11:0] low_thresh, // low threshold
   input wire logic [5:0] hyst, // hysteresis, both comparators
   input wire logic [3:0] event_limit, // count field, events = field + 1
   output logic [1:0] hit // bit0 low alert, bit1 high alert, pulses
);
   logic [1:0] cmp_state; // bit0 low side, bit1 high side
   logic [1:0] cmp_now; // comparator outputs after this sample
   logic [12:0] low_release; // low threshold plus hysteresis
   logic [12:0] high_release; // sample plus hysteresis
   logic [4:0] run_count [2]; // consecutive set conversions

   // comparators, hysteresis widens the release point only
   always_comb
   begin
      low_release = {1'b0, low_thresh} + {7'h00, hyst};
      high_release = {1'b0, sample_data} + {7'h00, hyst};
      cmp_now[0] = (sample_data <= low_thresh) ||
         (cmp_state[0] && ({1'b0, sample_data} <= low_release));
      cmp_now[1] = (sample_data >= high_thresh) ||
         (cmp_state[1] && (high_release >= {1'b0, high_thresh}));
   end

   // comparator state updates on each conversion
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cmp_state <= 2'h0;
      end
      else if (restart)
      begin
         cmp_state <= 2'h0;
      end
      else if (sample_valid)
      begin
         cmp_state <= cmp_now;
      end
   end

   // one shared count limit for both comparators
   for (genvar i = 0; i < 2; i++)
   begin : g_count
      always_ff @(posedge clk_sys or negedge reset_n)
      begin
         if (!reset_n)
         begin
            run_count[i] <= 5'h00;
            hit[i] <= 1'b0;
         end
         else if (restart)
         begin
            run_count[i] <= 5'h00;
            hit[i] <= 1'b0;
         end
         else if (sample_valid && cmp_now[i])
         begin
            run_count[i] <= (run_count[i] == 5'h1F) ? run_count[i] : run_count[i] + 5'h01;
            hit[i] <= (run_count[i] >= {1'b0, event_limit});
         end
         else
         begin
            if (sample_valid)
            begin
               run_count[i] <= 5'h00; // a clear sample breaks the run
            end
            hit[i] <= 1'b0;
         end
      end

      property p_hit_needs_run;
         @(posedge clk_sys) disable iff (!reset_n) $rose(hit[i]) |-> ($past(run_count[i]) >= {1'b0, $past(event_limit)});
      endproperty
      a_hit_needs_run: assert property (p_hit_needs_run) else $error("alert before event count");
   end

   property p_low_sets;
      @(posedge clk_sys) disable iff (!reset_n)
         (sample_valid && !restart && sample_data <= low_thresh) |=> cmp_state[0];
   endproperty
   a_low_sets: assert property (p_low_sets) else $error("low comparator not set");

   c_high_hit: cover property (@(posedge clk_sys) disable iff (!reset_n) hit[1]);
endmodule // window_channel_compare

/* File: window_comparator_alert_status.sv */
module window_comparator_alert_status (
   input wire logic clk_sys, // system clock, 100 MHz
   input wire logic reset_n, // async power-up reset, active low
   input wire logic reg_wr, // register write strobe from serial engine
   input wire logic reg_rd, // register read strobe
   input wire logic [7:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // register write data
   output logic [7:0] reg_rdata, // read data, one cycle after strobe
   input wire logic soft_reset, // general-call software reset pulse
   input wire logic device_reset, // device reset pulse
   input wire logic sequence_go_bit, // host wrote 1 to start bit, pulse
   input wire logic conv_valid, // conversion result strobe
   input wire logic conv_channel, // channel of the result
   input wire logic [11:0] conv_data, // conversion result
   output logic alert_out // alert output, high while any flag set
);
   logic [3:0] thr_msb [4]; // threshold upper nibbles, slot 2c high, 2c+1 low
   logic [7:0] thr_lsb [4]; // threshold lower bytes
   logic [5:0] hyst [2]; // per-channel hysteresis
   logic [3:0] event_count_field; // shared pre-alert count field
   logic [3:0] first_alert_channel; // first channel to alert
   logic chid_valid; // first channel already captured
   logic [1:0] low_hit; // low alert events per channel
   logic [1:0] high_hit; // high alert events per channel
   logic [1:0] low_flags; // latched low flags
   logic [1:0] high_flags; // latched high flags
   logic [7:0] next_rdata; // read value for the addressed register
   logic chid_clear; // any event clearing the channel id
   logic [3:0] thr_sel; // threshold decode of the current address
   logic [1:0] hyst_sel; // hysteresis decode of the current address

   // threshold decode: {hit, slot[1:0], msb}
   function automatic logic [3:0] thr_decode(input logic [7:0] a);
      thr_decode = {a[7:3] == alert_regs_pkg::THRESH_BASE_OFS[7:3], a[2:1], a[0]};
   endfunction

   // hysteresis decode: {hit, channel}
   function automatic logic [1:0] hyst_decode(input logic [7:0] a);
      hyst_decode = {a[7:1] == alert_regs_pkg::HYST_BASE_OFS[7:1], a[0]};
   endfunction

   assign chid_clear = soft_reset || device_reset || sequence_go_bit;

   // address decodes, shared by the write and read paths
   assign thr_sel = thr_decode(reg_addr);
   assign hyst_sel = hyst_decode(reg_addr);

   // configuration registers written by the host
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int s = 0; s < 4; s++)
         begin
            thr_msb[s] <= alert_regs_pkg::MSB_RESET;
            thr_lsb[s] <= alert_regs_pkg::REG_RESET;
         end
         hyst[0] <= alert_regs_pkg::HYST_RESET;
         hyst[1] <= alert_regs_pkg::HYST_RESET;
         event_count_field <= alert_regs_pkg::COUNT_RESET;
      end
      else if (soft_reset)
      begin
         for (int s = 0; s < 4; s++)
         begin
            thr_msb[s] <= alert_regs_pkg::MSB_RESET;
            thr_lsb[s] <= alert_regs_pkg::REG_RESET;
         end
         hyst[0] <= alert_regs_pkg::HYST_RESET;
         hyst[1] <= alert_regs_pkg::HYST_RESET;
         event_count_field <= alert_regs_pkg::COUNT_RESET;
      end
      else if (reg_wr)
      begin
         // threshold halves, msb keeps only four bits
         if (thr_sel[3])
         begin
            if (thr_sel[0])
            begin
               thr_msb[thr_sel[2:1]] <= reg_wdata[3:0];
            end
            else
            begin
               thr_lsb[thr_sel[2:1]] <= reg_wdata;
            end
         end
         // hysteresis, top two bits dropped
         if (hyst_sel[1])
         begin
            hyst[hyst_sel[0]] <= reg_wdata[5:0];
         end
         // shared event count in the upper nibble
         if (reg_addr == alert_regs_pkg::EVENT_COUNT_OFS)
         begin
            event_count_field <= reg_wdata[alert_regs_pkg::EVENT_FIELD_LSB +: 4];
         end
      end
   end

   // per-channel comparators share one count field
   for (genvar c = 0; c < 2; c++)
   begin : g_chan
      logic [1:0] chan_hit; // bit0 low, bit1 high

      window_channel_compare u_compare (
         .clk_sys(clk_sys),
         .reset_n(reset_n),
         .restart(soft_reset || sequence_go_bit),
         .sample_valid(conv_valid && (conv_channel == 1'(c))),
         .sample_data(conv_data),
         .high_thresh({thr_msb[2 * c], thr_lsb[2 * c]}),
         .low_thresh({thr_msb[2 * c + 1], thr_lsb[2 * c + 1]}),
         .hyst(hyst[c]),
         .event_limit(event_count_field),
         .hit(chan_hit)
      );

      assign low_hit[c] = chan_hit[0];
      assign high_hit[c] = chan_hit[1];
   end

   // latched low flags
   alert_flag_bank #(
      .WIDTH(alert_regs_pkg::FLAG_WIDTH)
   ) u_low_flags (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .set_pulse(low_hit),
      .clr_wr(reg_wr && reg_addr == alert_regs_pkg::LOW_FLAGS_OFS),
      .clr_data(reg_wdata[1:0]),
      .soft_clear(soft_reset),
      .flags(low_flags)
   );

   // latched high flags
   alert_flag_bank #(
      .WIDTH(alert_regs_pkg::FLAG_WIDTH)
   ) u_high_flags (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .set_pulse(high_hit),
      .clr_wr(reg_wr && reg_addr == alert_regs_pkg::HIGH_FLAGS_OFS),
      .clr_data(reg_wdata[1:0]),
      .soft_clear(soft_reset),
      .flags(high_flags)
   );

   // first alerting channel, captured once until cleared
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         first_alert_channel <= alert_regs_pkg::CHID_CHAN0;
         chid_valid <= 1'b0;
      end
      else if (chid_clear)
      begin
         first_alert_channel <= alert_regs_pkg::CHID_CHAN0;
         chid_valid <= 1'b0;
      end
      else if (!chid_valid && (|(low_hit | high_hit)))
      begin
         // channel 0 taken if both alert together
         first_alert_channel <= (low_hit[0] || high_hit[0]) ?
            alert_regs_pkg::CHID_CHAN0 : alert_regs_pkg::CHID_CHAN1;
         chid_valid <= 1'b1;
      end
   end

   // alert output follows the latched flags
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         alert_out <= 1'b0;
      end
      else
      begin
         alert_out <= |{low_flags, high_flags};
      end
   end

   // read multiplexer, unmapped addresses read zero
   always_comb
   begin
      next_rdata = alert_regs_pkg::REG_RESET;
      if (thr_sel[3])
      begin
         next_rdata = thr_sel[0] ? {4'h0, thr_msb[thr_sel[2:1]]} : thr_lsb[thr_sel[2:1]];
      end
      else if (hyst_sel[1])
      begin
         next_rdata = {2'h0, hyst[hyst_sel[0]]};
      end
      else
      begin
         case (reg_addr)
            alert_regs_pkg::FIRST_ALERT_OFS: next_rdata = {first_alert_channel, 4'h0};
            alert_regs_pkg::LOW_FLAGS_OFS: next_rdata = {6'h00, low_flags};
            alert_regs_pkg::HIGH_FLAGS_OFS: next_rdata = {6'h00, high_flags};
            alert_regs_pkg::EVENT_COUNT_OFS: next_rdata = {event_count_field, 4'h0};
            default: next_rdata = alert_regs_pkg::REG_RESET;
         endcase
      end
   end

   // read data register, held between reads
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         reg_rdata <= alert_regs_pkg::REG_RESET;
      end
      else if (reg_rd)
      begin
         reg_rdata <= next_rdata;
      end
   end

   property p_chid_held;
      @(posedge clk_sys) disable iff (!reset_n) (chid_valid && !chid_clear) |=> $stable(first_alert_channel);
   endproperty
   a_chid_held: assert property (p_chid_held) else $error("first channel overwritten");

   property p_chid_codes;
      @(posedge clk_sys) disable iff (!reset_n) first_alert_channel[3:1] == 3'h0;
   endproperty
   a_chid_codes: assert property (p_chid_codes) else $error("unused channel code");

   property p_chid_clear;
      @(posedge clk_sys) disable iff (!reset_n)
         chid_clear |=> (!chid_valid && first_alert_channel == alert_regs_pkg::CHID_CHAN0);
   endproperty
   a_chid_clear: assert property (p_chid_clear) else $error("channel id not cleared");

   property p_flag_reserved;
      @(posedge clk_sys) disable iff (!reset_n)
         (reg_rd && (reg_addr == alert_regs_pkg::LOW_FLAGS_OFS || reg_addr == alert_regs_pkg::HIGH_FLAGS_OFS))
         |=> reg_rdata[7:2] == 6'h00;
   endproperty
   a_flag_reserved: assert property (p_flag_reserved) else $error("reserved flag bits set");

   property p_msb_write;
      @(posedge clk_sys) disable iff (!reset_n)
         (reg_wr && !soft_reset && reg_addr == 8'h39) |=> thr_msb[0] == $past(reg_wdata[3:0]);
   endproperty
   a_msb_write: assert property (p_msb_write) else $error("threshold msb not stored");

   property p_hyst1_write;
      @(posedge clk_sys) disable iff (!reset_n)
         (reg_wr && !soft_reset && reg_addr == 8'h41) |=> hyst[1] == $past(reg_wdata[5:0]);
   endproperty
   a_hyst1_write: assert property (p_hyst1_write) else $error("hysteresis not stored");

   property p_alert_follows;
      @(posedge clk_sys) disable iff (!reset_n) (|(low_hit | high_hit)) |=> ##1 alert_out;
   endproperty
   a_alert_follows: assert property (p_alert_follows) else $error("alert output missing");

   // alert output never rises without a latched flag behind it
   property p_alert_quiet;
      @(posedge clk_sys) disable iff (!reset_n) !(|{low_flags, high_flags}) |=> !alert_out;
   endproperty
   a_alert_quiet: assert property (p_alert_quiet) else $error("alert without flag");

   // shared count field takes the upper nibble of the write
   property p_count_write;
      @(posedge clk_sys) disable iff (!reset_n)
         (reg_wr && !soft_reset && reg_addr == alert_regs_pkg::EVENT_COUNT_OFS)
         |=> event_count_field == $past(reg_wdata[alert_regs_pkg::EVENT_FIELD_LSB +: 4]);
   endproperty
   a_count_write: assert property (p_count_write) else $error("count field not stored");

   // soft reset brings the configuration back to zero
   property p_soft_config;
      @(posedge clk_sys) disable iff (!reset_n) soft_reset
         |=> (event_count_field == alert_regs_pkg::COUNT_RESET && hyst[1] == alert_regs_pkg::HYST_RESET);
   endproperty
   a_soft_config: assert property (p_soft_config) else $error("config not restored");

   // a lone channel 1 alert is recorded as channel 1
   property p_chid_first;
      @(posedge clk_sys) disable iff (!reset_n)
         (!chid_valid && !chid_clear && !(low_hit[0] || high_hit[0]) && (low_hit[1] || high_hit[1]))
         |=> first_alert_channel == alert_regs_pkg::CHID_CHAN1;
   endproperty
   a_chid_first: assert property (p_chid_first) else $error("first channel not captured");

   c_alert_up: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(alert_out));

   c_chan1_first: cover property (@(posedge clk_sys) disable iff (!reset_n)
      chid_valid && first_alert_channel == alert_regs_pkg::CHID_CHAN1);
   c_both_flags: cover property (@(posedge clk_sys) disable iff (!reset_n) low_flags[0] && high_flags[1]);
endmodule // window_comparator_alert_status

/* File: host_model.sv */
// host controller side of the register port, one access at a time
module host_model (
   input wire logic clk_sys, // system clock from the bench
   input wire logic [7:0] reg_rdata, // read data from the block
   output logic reg_wr, // write strobe
   output logic reg_rd, // read strobe
   output logic [7:0] reg_addr, // register address
   output logic [7:0] reg_wdata // write data
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus at time zero
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // one write: strobe held for the single edge that takes it
   // flag clears are issued between conversions, except in t_collision where one lands on the edge that sets the flag
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // one read: data taken at the following edge, while the loaded value stands
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      d = reg_rdata;
   endtask
endmodule // host_model

/* File: testbench.sv */
// self-checking bench for the alert status registers
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0; // system clock
   logic reset_n = 1'b0; // async reset, active low
   logic [2:0] ctl = 3'b000; // start, device reset, soft reset pulses
   logic conv_valid = 1'b0; // conversion strobe
   logic conv_channel = 1'b0; // conversion channel
   logic [11:0] conv_data = 12'h000; // conversion result
   logic alert_out; // alert output
   logic reg_wr; // write strobe from the host model
   logic reg_rd; // read strobe from the host model
   logic [7:0] reg_addr; // register address
   logic [7:0] reg_wdata; // write data
   logic [7:0] reg_rdata; // read data from the block
   int miscompares = 0; // mismatches
   int tests_run = 0; // comparisons made
   // register port driver
   host_model host (
      .clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata)
   );
   // 100 MHz clock
   always #5 clk_sys = ~clk_sys;
   window_comparator_alert_status dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .soft_reset(ctl[2]), .device_reset(ctl[1]), .sequence_go_bit(ctl[0]),
      .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_data(conv_data),
      .alert_out(alert_out)
   );
   // verdict and end of run
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
      begin
         $display("Result: passed");
      end
      else
      begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // compare seen against expected
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // read a register and compare
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.read_reg(a, d);
      check(d, exp);
   endtask
   // n back-to-back conversions, then let flags settle
   task automatic conv(input logic ch, input logic [11:0] d, input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         conv_valid <= 1'b1;
         conv_channel <= ch;
         conv_data <= d;
      end
      @(posedge clk_sys);
      conv_valid <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   // one-cycle control pulse
   task automatic pulse(input logic [2:0] p);
      @(posedge clk_sys);
      ctl <= p;
      @(posedge clk_sys);
      ctl <= 3'b000;
   endtask
   // reset values, read-only id, unmapped and reserved bits
   task automatic t_reset_values();
      host.write_reg(8'h03, 8'hFF);
      host.write_reg(8'h0C, 8'hFF);
      rd_chk(8'h03, 8'h00);
      rd_chk(8'h0C, 8'h00);
      rd_chk(8'h0E, 8'h00);
      rd_chk(8'h36, 8'h00);
      rd_chk(8'h41, 8'h00);
      rd_chk(8'h20, 8'h00); // unmapped reads zero
   endtask
   // config fields keep only their own bits
   task automatic t_config();
      host.write_reg(8'h36, 8'hFF);
      host.write_reg(8'h41, 8'hFF);
      rd_chk(8'h36, 8'hF0);
      rd_chk(8'h41, 8'h3F);
      host.write_reg(8'h41, 8'h00);
      // high thresholds FFFh, low thresholds 100
      host.write_reg(8'h38, 8'hFF);
      host.write_reg(8'h39, 8'h0F);
      host.write_reg(8'h3C, 8'hFF);
      host.write_reg(8'h3D, 8'h0F);
      host.write_reg(8'h3A, 8'h64);
      host.write_reg(8'h3E, 8'h64);
      rd_chk(8'h39, 8'h0F);
   endtask
   // event count of three, restart by a clear sample, first channel kept
   task automatic t_event_count();
      host.write_reg(8'h36, 8'h20);
      conv(1'b1, 12'h064, 2);
      conv(1'b1, 12'h0C8, 1);
      conv(1'b1, 12'h064, 2);
      rd_chk(8'h0C, 8'h00);
      conv(1'b1, 12'h064, 1);
      rd_chk(8'h0C, 8'h02);
      rd_chk(8'h03, 8'h10);
      check({7'h00, alert_out}, 8'h01); // alert raised
      conv(1'b0, 12'h064, 3);
      rd_chk(8'h0C, 8'h03);
      rd_chk(8'h03, 8'h10);
      conv(1'b0, 12'hFFF, 3);
      conv(1'b1, 12'hFFF, 3);
      rd_chk(8'h0E, 8'h03);
   endtask
   // write-one clears only the marked flags
   task automatic t_clear();
      host.write_reg(8'h0C, 8'h01);
      rd_chk(8'h0C, 8'h02);
      host.write_reg(8'h0C, 8'h00);
      rd_chk(8'h0C, 8'h02);
      host.write_reg(8'h0E, 8'hFF);
      host.write_reg(8'h0C, 8'hFF);
      rd_chk(8'h0E, 8'h00);
      rd_chk(8'h0C, 8'h00);
      check({7'h00, alert_out}, 8'h00); // alert dropped
   endtask
   // flag set and clear landing on the same edge
   task automatic t_collision();
      host.write_reg(8'h36, 8'h00);
      fork
         conv(1'b1, 12'h032, 1);
         begin
            // clear write sampled on the edge that sets the flag
            @(posedge clk_sys);
            host.write_reg(8'h0C, 8'h02);
         end
      join
      rd_chk(8'h0C, 8'h02);
      host.write_reg(8'h0C, 8'h02);
   endtask
   // channel 1 hysteresis holds the low comparator until 110
   task automatic t_hysteresis();
      host.write_reg(8'h41, 8'h0A);
      conv(1'b1, 12'h064, 1);
      host.write_reg(8'h0C, 8'h02);
      conv(1'b1, 12'h069, 1);
      rd_chk(8'h0C, 8'h02);
      host.write_reg(8'h0C, 8'h02);
      conv(1'b1, 12'h06F, 1);
      conv(1'b1, 12'h069, 1);
      rd_chk(8'h0C, 8'h00);
   endtask
   // start, device reset and soft reset clear the channel id
   task automatic t_clear_events();
      host.write_reg(8'h0E, 8'hFF);
      pulse(3'b001);
      rd_chk(8'h03, 8'h00);
      conv(1'b1, 12'h032, 1);
      rd_chk(8'h03, 8'h10);
      host.write_reg(8'h0C, 8'hFF);
      pulse(3'b010);
      rd_chk(8'h03, 8'h00);
      conv(1'b1, 12'h032, 1);
      rd_chk(8'h03, 8'h10);
      pulse(3'b100);
      rd_chk(8'h03, 8'h00);
      rd_chk(8'h0C, 8'h00);
      rd_chk(8'h41, 8'h00);
   endtask
   // watchdog
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      summarize();
   end
   // main sequence
   initial
   begin
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_reset_values();
      t_config();
      t_event_count();
      t_clear();
      t_collision();
      t_hysteresis();
      t_clear_events();
      summarize();
   end
endmodule // testbench
